// ==== common/crf_pkg.sv ====
// constants for the cpu register set and condition flags block
// How it works
// - seven 8-bit working registers: accumulator, four data, two pointer registers
// - only accumulator adds, subtracts, rotates; others increment, decrement, store
// - high and low pointer registers concatenate into one memory address
// - carry changes on accumulator overflow or underflow; some instructions force it
// - zero flag set when flag-setting result in accumulator is zero
// - after increment or decrement, zero flag shows if that register became zero
// - sign flag copies the most significant bit of the accumulator result
// - parity flag set when count of one bits is even
// - all flags forcible by some instructions; other instructions leave flags alone
// - load and data transfer instructions never touch any flag
// - conditional instructions sample current flags to decide whether control transfers
// - decoder takes 8-bit words, recognises 250 of 256 patterns
// - word splits into 2-bit top field and two 3-bit fields
// - 48 basic types: memory, register and port operations
// - register code: accumulator 0, data 1 to 4, high pointer 5, low 6
package crf_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_REGS = 7;
    localparam int unsigned ADDR_W = 12;

    // apb register map, byte addresses
    localparam logic [11:0] OFS_INSTR = 12'h000;
    localparam logic [11:0] OFS_OPERAND = 12'h004;
    localparam logic [11:0] OFS_FLAGS = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00C;
    localparam logic [11:0] OFS_ADDR = 12'h010;
    localparam logic [11:0] OFS_MEMOUT = 12'h014;
    localparam logic [11:0] OFS_REG_BASE = 12'h020;
    localparam logic [6:0] REG_PAGE = 7'h01;

    // instruction word fields
    localparam int unsigned FLD_HI_MSB = 7;
    localparam int unsigned FLD_HI_LSB = 6;
    localparam int unsigned FLD_MID_MSB = 5;
    localparam int unsigned FLD_MID_LSB = 3;
    localparam int unsigned FLD_LO_MSB = 2;
    localparam int unsigned FLD_LO_LSB = 0;

    localparam logic [1:0] GRP_MISC = 2'h0;
    localparam logic [1:0] GRP_CTL = 2'h1;
    localparam logic [1:0] GRP_ALU = 2'h2;
    localparam logic [1:0] GRP_LOAD = 2'h3;

    localparam logic [2:0] LO_INC = 3'h0;
    localparam logic [2:0] LO_DEC = 3'h1;
    localparam logic [2:0] LO_ROT = 3'h2;
    localparam logic [2:0] LO_RETC = 3'h3;
    localparam logic [2:0] LO_ALUI = 3'h4;
    localparam logic [2:0] LO_RST = 3'h5;
    localparam logic [2:0] LO_LDI = 3'h6;
    localparam logic [2:0] LO_RET = 3'h7;
    localparam logic [2:0] LO_JMPC = 3'h0;
    localparam logic [2:0] LO_CALC = 3'h2;
    localparam logic [2:0] LO_JMP = 3'h4;
    localparam logic [2:0] LO_CAL = 3'h6;
    localparam logic [7:0] OP_HALT_ALT = 8'hFF;

    // register codes
    localparam logic [2:0] REG_A = 3'h0;
    localparam logic [2:0] REG_B = 3'h1;
    localparam logic [2:0] REG_C = 3'h2;
    localparam logic [2:0] REG_D = 3'h3;
    localparam logic [2:0] REG_E = 3'h4;
    localparam logic [2:0] REG_H = 3'h5;
    localparam logic [2:0] REG_L = 3'h6;
    localparam logic [2:0] REG_M = 3'h7;

    // alu operations
    localparam logic [2:0] ALU_ADD = 3'h0;
    localparam logic [2:0] ALU_ADC = 3'h1;
    localparam logic [2:0] ALU_SUB = 3'h2;
    localparam logic [2:0] ALU_SBB = 3'h3;
    localparam logic [2:0] ALU_AND = 3'h4;
    localparam logic [2:0] ALU_XOR = 3'h5;
    localparam logic [2:0] ALU_OR = 3'h6;
    localparam logic [2:0] ALU_CMP = 3'h7;

    // rotate kinds
    localparam logic [2:0] ROT_LC = 3'h0;
    localparam logic [2:0] ROT_RC = 3'h1;
    localparam logic [2:0] ROT_AL = 3'h2;
    localparam logic [2:0] ROT_AR = 3'h3;

    // flag bit positions, also the condition codes
    localparam int unsigned FLG_C = 0;
    localparam int unsigned FLG_Z = 1;
    localparam int unsigned FLG_S = 2;
    localparam int unsigned FLG_P = 3;
    localparam logic [3:0] FLAGS_RST = 4'h0;

    // status bit positions
    localparam int unsigned ST_VALID = 0;
    localparam int unsigned ST_TAKEN = 1;
    localparam int unsigned ST_COND = 2;
    localparam int unsigned ST_HALT = 3;
    localparam int unsigned ST_MEMWR = 4;
    localparam logic [4:0] STATUS_RST = 5'h00;

    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
endpackage

// ==== verilog/crf_alu.sv ====
// accumulator arithmetic and logic unit
module crf_alu (
    input wire logic [2:0] i_op,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic i_cin,
    output logic [7:0] o_res,
    output logic o_cout
);
    logic [8:0] sum;

    always_comb begin
        sum = 9'h000;
        o_res = crf_pkg::BYTE_RST;
        o_cout = 1'b0;
        case (i_op)
            crf_pkg::ALU_ADD, crf_pkg::ALU_ADC: begin
                sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_op[0] & i_cin};
                o_res = sum[7:0];
                o_cout = sum[8];
            end
            crf_pkg::ALU_SUB, crf_pkg::ALU_SBB, crf_pkg::ALU_CMP: begin
                // borrow out lands in bit 8
                sum = {1'b0, i_a} - {1'b0, i_b} - {8'h00, (i_op == crf_pkg::ALU_SBB) & i_cin};
                o_res = sum[7:0];
                o_cout = sum[8];
            end
            // logic ops force carry to zero
            crf_pkg::ALU_AND: o_res = i_a & i_b;
            crf_pkg::ALU_XOR: o_res = i_a ^ i_b;
            crf_pkg::ALU_OR: o_res = i_a | i_b;
            default: o_res = crf_pkg::BYTE_RST;
        endcase
    end
endmodule // crf_alu

// ==== verilog/crf_core.sv ====
// register set, condition flags and instruction decode behind an apb slave
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
module crf_core (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [15:0] o_mem_addr,
    output logic [3:0] o_flags,
    output logic o_taken
);
    logic [7:0] rf_q [0:crf_pkg::NUM_REGS-1];
    logic [3:0] flags_q;
    logic [7:0] operand_q;
    logic [7:0] instr_q;
    logic [7:0] memout_q;
    logic [4:0] status_q;

    logic setup;
    logic access;
    logic exec;
    logic reg_wr;
    logic [2:0] reg_idx;
    logic reg_hit;
    logic [31:0] rdata_c;
    logic err_c;

    logic [7:0] ins;
    logic [1:0] grp;
    logic [2:0] mid;
    logic [2:0] lo;
    logic [7:0] src_val;
    logic valid;
    logic wr_en;
    logic [2:0] wr_idx;
    logic [7:0] wr_val;
    logic upd_zsp;
    logic [7:0] zsp_src;
    logic upd_c;
    logic c_val;
    logic mem_wr;
    logic [7:0] mem_val;
    logic is_cond;
    logic taken;
    logic halt;
    logic [2:0] alu_op;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic [7:0] alu_res;
    logic alu_cout;

    function automatic logic [7:0] rd_reg(input logic [2:0] idx, input logic [7:0] mem);
        logic [7:0] v;
        v = mem;
        if (idx != crf_pkg::REG_M) begin
            v = rf_q[idx];
        end
        return v;
    endfunction

    // flag comparison for conditional jumps, calls and returns
    function automatic logic cond_hit(input logic [3:0] f, input logic [2:0] m);
        return f[m[1:0]] == m[2];
    endfunction

    assign setup = i_psel & ~i_penable;
    assign access = i_psel & i_penable & o_pready;
    // strobe 0 must be set, so a write that skips the low byte runs nothing
    assign exec = access & i_pwrite & i_pstrb[0] & (i_paddr == crf_pkg::OFS_INSTR);
    assign reg_idx = i_paddr[4:2];
    assign reg_hit = (i_paddr[11:5] == crf_pkg::REG_PAGE) & (reg_idx != crf_pkg::REG_M)
        & (i_paddr[1:0] == 2'h0);
    assign reg_wr = access & i_pwrite & i_pstrb[0] & reg_hit;

    // fields of the 8-bit instruction word
    assign ins = i_pwdata[7:0];
    assign grp = ins[crf_pkg::FLD_HI_MSB:crf_pkg::FLD_HI_LSB];
    assign mid = ins[crf_pkg::FLD_MID_MSB:crf_pkg::FLD_MID_LSB];
    assign lo = ins[crf_pkg::FLD_LO_MSB:crf_pkg::FLD_LO_LSB];
    // code 7 reads memory, which this block only sees as the operand byte
    assign src_val = rd_reg(lo, operand_q);

    crf_alu i_crf_alu (
        .i_op(alu_op),
        .i_a(alu_a),
        .i_b(alu_b),
        .i_cin(flags_q[crf_pkg::FLG_C]),
        .o_res(alu_res),
        .o_cout(alu_cout)
    );

    // decode; unlisted patterns leave every working register and flag alone
    always_comb begin
        valid = 1'b0;
        wr_en = 1'b0;
        wr_idx = crf_pkg::REG_A;
        wr_val = crf_pkg::BYTE_RST;
        upd_zsp = 1'b0;
        zsp_src = alu_res;
        upd_c = 1'b0;
        c_val = flags_q[crf_pkg::FLG_C];
        mem_wr = 1'b0;
        mem_val = src_val;
        is_cond = 1'b0;
        taken = 1'b0;
        halt = 1'b0;
        alu_op = crf_pkg::ALU_ADD;
        alu_a = rf_q[crf_pkg::REG_A];
        alu_b = src_val;
        case (grp)
            crf_pkg::GRP_LOAD: begin
                valid = 1'b1;
                // a move of a register onto itself is a plain no-operation, but code 7 onto code 7 halts
                if (ins == crf_pkg::OP_HALT_ALT) begin
                    halt = 1'b1;
                end else if (mid == crf_pkg::REG_M) begin
                    mem_wr = 1'b1;
                end else begin
                    wr_en = 1'b1;
                    wr_idx = mid;
                    wr_val = src_val;
                end
            end
            crf_pkg::GRP_ALU: begin
                valid = 1'b1;
                alu_op = mid;
                wr_en = (mid != crf_pkg::ALU_CMP);
                wr_val = alu_res;
                upd_zsp = 1'b1;
                upd_c = 1'b1;
                c_val = alu_cout;
            end
            crf_pkg::GRP_MISC: begin
                case (lo)
                    crf_pkg::LO_INC, crf_pkg::LO_DEC: begin
                        valid = (mid != crf_pkg::REG_M);
                        if (mid == crf_pkg::REG_A) begin
                            halt = 1'b1;
                        end else if (mid != crf_pkg::REG_M) begin
                            // inc and dec on non-accumulators; carry is kept
                            alu_op = lo[0] ? crf_pkg::ALU_SUB : crf_pkg::ALU_ADD;
                            alu_a = rd_reg(mid, operand_q);
                            alu_b = crf_pkg::BYTE_ONE;
                            wr_en = 1'b1;
                            wr_idx = mid;
                            wr_val = alu_res;
                            upd_zsp = 1'b1;
                        end
                    end
                    crf_pkg::LO_ROT: begin
                        valid = ~mid[2];
                        if (~mid[2]) begin
                            wr_en = 1'b1;
                            upd_c = 1'b1;
                            case (mid)
                                crf_pkg::ROT_LC: begin
                                    wr_val = {alu_a[6:0], alu_a[7]};
                                    c_val = alu_a[7];
                                end
                                crf_pkg::ROT_RC: begin
                                    wr_val = {alu_a[0], alu_a[7:1]};
                                    c_val = alu_a[0];
                                end
                                crf_pkg::ROT_AL: begin
                                    wr_val = {alu_a[6:0], flags_q[crf_pkg::FLG_C]};
                                    c_val = alu_a[7];
                                end
                                default: begin
                                    wr_val = {flags_q[crf_pkg::FLG_C], alu_a[7:1]};
                                    c_val = alu_a[0];
                                end
                            endcase
                        end
                    end
                    crf_pkg::LO_RETC: begin
                        valid = 1'b1;
                        is_cond = 1'b1;
                        taken = cond_hit(flags_q, mid);
                    end
                    crf_pkg::LO_ALUI: begin
                        valid = 1'b1;
                        alu_op = mid;
                        alu_b = operand_q;
                        wr_en = (mid != crf_pkg::ALU_CMP);
                        wr_val = alu_res;
                        upd_zsp = 1'b1;
                        upd_c = 1'b1;
                        c_val = alu_cout;
                    end
                    crf_pkg::LO_LDI: begin
                        valid = 1'b1;
                        mem_val = operand_q;
                        if (mid == crf_pkg::REG_M) begin
                            mem_wr = 1'b1;
                        end else begin
                            wr_en = 1'b1;
                            wr_idx = mid;
                            wr_val = operand_q;
                        end
                    end
                    default: begin
                        // restart and unconditional return
                        valid = 1'b1;
                        taken = 1'b1;
                    end
                endcase
            end
            default: begin
                valid = 1'b1;
                if (lo[0]) begin
                    // port input lands in the accumulator, flags untouched
                    if (mid[2:1] == 2'h0) begin
                        wr_en = 1'b1;
                        wr_val = operand_q;
                    end
                end else if (lo == crf_pkg::LO_JMPC || lo == crf_pkg::LO_CALC) begin
                    is_cond = 1'b1;
                    taken = cond_hit(flags_q, mid);
                end else begin
                    taken = 1'b1;
                end
            end
        endcase
    end

    // working registers: instruction writes, or plain software stores
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            for (int i = 0; i < crf_pkg::NUM_REGS; i++) begin
                rf_q[i] <= crf_pkg::BYTE_RST;
            end
        end else if (exec && wr_en) begin
            rf_q[wr_idx] <= wr_val;
        end else if (reg_wr) begin
            rf_q[reg_idx] <= i_pwdata[7:0];
        end
    end

    // flags move only for flag-setting instructions
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            flags_q <= crf_pkg::FLAGS_RST;
        end else if (exec) begin
            if (upd_c) begin
                flags_q[crf_pkg::FLG_C] <= c_val;
            end
            if (upd_zsp) begin
                flags_q[crf_pkg::FLG_Z] <= (zsp_src == crf_pkg::BYTE_RST);
                flags_q[crf_pkg::FLG_S] <= zsp_src[7];
                flags_q[crf_pkg::FLG_P] <= ~^zsp_src;
            end
        end
    end

    // last instruction outcome and memory store data
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            instr_q <= crf_pkg::BYTE_RST;
            status_q <= crf_pkg::STATUS_RST;
            memout_q <= crf_pkg::BYTE_RST;
            o_taken <= 1'b0;
        end else if (exec) begin
            instr_q <= ins;
            status_q[crf_pkg::ST_VALID] <= valid;
            status_q[crf_pkg::ST_TAKEN] <= taken;
            status_q[crf_pkg::ST_COND] <= is_cond;
            status_q[crf_pkg::ST_HALT] <= halt;
            status_q[crf_pkg::ST_MEMWR] <= mem_wr;
            o_taken <= taken;
            if (mem_wr) begin
                memout_q <= mem_val;
            end
        end
    end

    // data byte stays until software rewrites it, so one operand serves many opcodes
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            operand_q <= crf_pkg::BYTE_RST;
        end else if (access && i_pwrite && i_pstrb[0] && i_paddr == crf_pkg::OFS_OPERAND) begin
            operand_q <= i_pwdata[7:0];
        end
    end

    // read mux; read-only registers refuse writes with an error
    always_comb begin
        rdata_c = 32'h0000_0000;
        err_c = 1'b0;
        case (i_paddr)
            crf_pkg::OFS_INSTR: rdata_c = {24'h00_0000, instr_q};
            crf_pkg::OFS_OPERAND: rdata_c = {24'h00_0000, operand_q};
            crf_pkg::OFS_FLAGS: begin
                rdata_c = {28'h000_0000, flags_q};
                err_c = i_pwrite;
            end
            crf_pkg::OFS_STATUS: begin
                rdata_c = {27'h000_0000, status_q};
                err_c = i_pwrite;
            end
            crf_pkg::OFS_ADDR: begin
                rdata_c = {16'h0000, rf_q[crf_pkg::REG_H], rf_q[crf_pkg::REG_L]};
                err_c = i_pwrite;
            end
            crf_pkg::OFS_MEMOUT: begin
                rdata_c = {24'h00_0000, memout_q};
                err_c = i_pwrite;
            end
            default: begin
                if (reg_hit) begin
                    rdata_c = {24'h00_0000, rf_q[reg_idx]};
                end else begin
                    err_c = 1'b1;
                end
            end
        endcase
    end

    // one wait-free access phase: answer is ready in the first access cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
        end else begin
            o_pready <= setup;
            o_pslverr <= setup & err_c;
            if (setup && !i_pwrite) begin
                o_prdata <= rdata_c;
            end
        end
    end

    // register outputs copied straight from flops
    assign o_mem_addr = {rf_q[crf_pkg::REG_H], rf_q[crf_pkg::REG_L]};
    assign o_flags = flags_q;
endmodule // crf_core

// ==== tb/crf_core_properties.sv ====
// checker of apb timing and flag, pointer and control stability on the core ports
module crf_core_checker (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [15:0] o_mem_addr,
    input wire logic [3:0] o_flags,
    input wire logic o_taken
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    logic wr_acc;
    logic exec;
    logic rst_seen_q = 1'b0;
    // outputs are unknown before the first reset edge, so that edge is not judged
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rst_seen_q <= 1'b1;
        end
    end
    assign wr_acc = i_psel && i_penable && i_pwrite && o_pready;
    assign exec = wr_acc && i_paddr == crf_pkg::OFS_INSTR;

    ready_after_setup_a: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready in first access cycle");
    ready_one_cycle_a: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    ready_in_access_a: assert property (o_pready |-> i_psel && i_penable)
        else $error("ready outside an access phase");
    err_with_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    flags_hold_a: assert property (!exec |=> $stable(o_flags))
        else $error("flags moved without an instruction");
    pointer_hold_a: assert property (!wr_acc |=> $stable(o_mem_addr))
        else $error("memory address moved without a write");
    taken_hold_a: assert property (!exec |=> $stable(o_taken))
        else $error("taken moved without an instruction");
    flags_readonly_a: assert property (wr_acc && i_paddr == crf_pkg::OFS_FLAGS |-> o_pslverr)
        else $error("flag register write not refused");
    load_no_flag_a: assert property (exec && i_pstrb[0] &&
        i_pwdata[7:6] == crf_pkg::GRP_LOAD |=> $stable(o_flags))
        else $error("load changed flags");
    // reset itself is the antecedent here, so the default disable is lifted
    reset_clear_a: assert property (disable iff (1'b0) rst_seen_q && $past(i_rst) |->
        o_flags == 4'h0 && !o_taken && o_mem_addr == 16'h0000)
        else $error("state not cleared by reset");

    exec_cov: cover property (exec ##1 $changed(o_flags));
    refuse_cov: cover property (o_pslverr);
    taken_cov: cover property ($rose(o_taken));
endmodule // crf_core_checker

bind crf_core crf_core_checker i_crf_core_checker (.i_ref_clk, .i_rst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .o_mem_addr,
    .o_flags, .o_taken);

// ==== tb/crf_core_bench.sv ====
// self-checking bench for the register set and condition flag block
module crf_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0] r;
        logic [7:0] pre;
        logic [7:0] opnd;
        logic [7:0] op;
        logic [7:0] res;
        logic [3:0] fl;
    } crf_case_s;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] mem_addr;
    logic [3:0] flags;
    logic taken;
    int failures = 0;
    int samples_checked = 0;

    always #12.5 ref_clk = ~ref_clk;

    crf_core i_crf_core (.i_ref_clk(ref_clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_mem_addr(mem_addr),
        .o_flags(flags), .o_taken(taken));

    task automatic tally_and_finish();
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset(input int n);
        rst <= 1'b1;
        repeat (n) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
    endtask

    // entered just after a rising edge, leaves one idle cycle behind it
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            failures++;
            tally_and_finish();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, {24'h0, d}, q, e);
        chk({31'h0, e}, 32'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask

    function automatic logic [11:0] ra(input int n);
        return crf_pkg::OFS_REG_BASE + 12'(4 * n);
    endfunction

    task automatic t_reset();
        chk({mem_addr, 7'h0, taken, 4'h0, flags}, 32'h0);
        for (int n = 0; n < crf_pkg::NUM_REGS; n++) rd(ra(n), 32'h0);
    endtask

    task automatic t_regs();
        for (int n = 0; n < 7; n++) wr(ra(n), 8'(8'h11 * (n + 1)));
        for (int n = 0; n < 7; n++) rd(ra(n), 32'(8'(8'h11 * (n + 1))));
        chk({16'h0, mem_addr}, 32'h6677);
        rd(crf_pkg::OFS_ADDR, 32'h6677);
        chk({28'h0, flags}, 32'h0);
    endtask

    // carry persists across rows, so the order matters
    task automatic t_exec();
        crf_case_s tbl [14] = '{
            '{3'h0, 8'h00, 8'h80, 8'h04, 8'h80, 4'h4}, '{3'h0, 8'h80, 8'h81, 8'h14, 8'hFF, 4'hD},
            '{3'h0, 8'h0F, 8'h03, 8'h24, 8'h03, 4'h8}, '{3'h0, 8'hFF, 8'h01, 8'h04, 8'h00, 4'hB},
            '{3'h0, 8'h55, 8'h00, 8'hC7, 8'h00, 4'hB}, '{3'h0, 8'h10, 8'h10, 8'hBF, 8'h10, 4'hA},
            '{3'h0, 8'hFF, 8'h01, 8'h8F, 8'h00, 4'hB}, '{3'h0, 8'h10, 8'h01, 8'h8F, 8'h12, 4'h8},
            '{3'h0, 8'h01, 8'h00, 8'h1A, 8'h00, 4'h9}, '{3'h0, 8'h33, 8'hF0, 8'h41, 8'hF0, 4'h9},
            '{3'h1, 8'hFF, 8'h00, 8'h08, 8'h00, 4'hB}, '{3'h1, 8'h00, 8'h00, 8'h09, 8'hFF, 4'hD},
            '{3'h1, 8'h55, 8'h00, 8'h0E, 8'h00, 4'hD}, '{3'h0, 8'h01, 8'h00, 8'h02, 8'h02, 4'hC}};
        foreach (tbl[i]) begin
            wr(ra(int'(tbl[i].r)), tbl[i].pre);
            wr(crf_pkg::OFS_OPERAND, tbl[i].opnd);
            wr(crf_pkg::OFS_INSTR, tbl[i].op);
            rd(ra(int'(tbl[i].r)), {24'h0, tbl[i].res});
            chk({28'h0, flags}, {28'h0, tbl[i].fl});
        end
    endtask

    task automatic t_cond();
        logic [3:0] f;
        logic [7:0] exp_taken;
        f = 4'hC;
        // with only sign and parity set, codes 0, 1, 6 and 7 jump
        exp_taken = 8'hC3;
        for (int c = 0; c < 8; c++) begin
            wr(crf_pkg::OFS_INSTR, 8'h40 | 8'(c << 3));
            chk({31'h0, taken}, {31'h0, exp_taken[c]});
        end
        wr(crf_pkg::OFS_INSTR, 8'h44);
        chk({31'h0, taken}, 32'h1);
        chk({28'h0, flags}, {28'h0, f});
    endtask

    task automatic t_refuse();
        logic [31:0] q;
        logic e;
        apb(1'b1, crf_pkg::OFS_FLAGS, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'h03C, 32'h0, q, e);
        chk({q[30:0], e}, 32'h1);
        wr(crf_pkg::OFS_INSTR, 8'h38);
        apb(1'b0, crf_pkg::OFS_STATUS, 32'h0, q, e);
        chk({31'h0, q[crf_pkg::ST_VALID]}, 32'h0);
        chk({27'h0, taken, flags}, 32'hC);
        wr(crf_pkg::OFS_OPERAND, 8'h5A);
        wr(crf_pkg::OFS_INSTR, 8'h3E);
        apb(1'b0, crf_pkg::OFS_STATUS, 32'h0, q, e);
        chk({31'h0, q[crf_pkg::ST_VALID]}, 32'h1);
        chk({27'h0, q[4:0]}, 32'h11);
        rd(crf_pkg::OFS_MEMOUT, 32'h5A);
        chk({28'h0, flags}, 32'hC);
    endtask

    initial begin
        do_reset(12);
        t_reset();
        t_regs();
        t_exec();
        t_cond();
        t_refuse();
        do_reset(2);
        chk({28'h0, flags}, 32'h0);
        tally_and_finish();
    end
endmodule // crf_core_bench
